// file: refr_pkg.sv
// shared constants, types and helpers for the rail enable and flag registers
package refr_pkg;

  // register offsets on the serial management bus
  localparam logic [7:0] ADDR_FLAGS     = 8'h07;
  localparam logic [7:0] ADDR_UNLOCK    = 8'h10;
  localparam logic [7:0] ADDR_CONV_EN   = 8'h11;
  localparam logic [7:0] ADDR_SWITCH_EN = 8'h12;

  // reset values, and the fixed read value of the unlock register
  localparam logic [7:0] RST_FLAGS      = 8'h00;
  localparam logic [7:0] RST_CONV_EN    = 8'h00;
  localparam logic [7:0] RST_SWITCH_EN  = 8'h00;
  localparam logic [7:0] READ_UNLOCK    = 8'h00;

  // writable field masks; the rest is reserved
  localparam logic [7:0] MASK_CONV_EN   = 8'h3f;
  localparam logic [7:0] MASK_SWITCH_EN = 8'h7f;

  // field positions in the converter enable register
  localparam int CONV5_BIT = 4;
  localparam int CONV6_BIT = 5;
  localparam logic [7:0] MASK_BACKUP    = 8'h30;
  localparam logic [7:0] MASK_SEQ_CONV  = 8'h1f;

  // field positions in the switch and output enable register
  localparam int LINREG_BIT  = 0;
  localparam int SWITCH1_BIT = 1;
  localparam int SWITCH2_BIT = 2;
  localparam int SWITCH3_BIT = 3;
  localparam int OUT1_BIT    = 4;
  localparam int OUT2_BIT    = 5;
  localparam int OUT3_BIT    = 6;

  // key scrambling of the unlock write; arbitrary value
  localparam logic [7:0] UNLOCK_XOR = 8'h5a;
  // serial bus device address; arbitrary value
  localparam logic [6:0] DEV_ADDR   = 7'h2a;
  localparam logic [3:0] BITS_BYTE  = 4'h8;

  typedef enum logic [2:0] {
    REFR_IDLE, REFR_RX, REFR_ACK, REFR_TX, REFR_TX_ACK
  } refr_state_t;

  typedef enum logic [1:0] {
    REFR_PH_ADDR, REFR_PH_PTR, REFR_PH_DATA
  } refr_phase_t;

  // new filtered level once the second and third stages agree
  function automatic logic refr_agree(input logic cur,
                                      input logic s2,
                                      input logic s3);
    refr_agree = (s2 == s3) ? s2 : cur;
  endfunction

endpackage

// file: refr_bus_if.sv
// register access carrier between the serial engine and the register bank
`timescale 1ns/100ps
interface refr_bus_if;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic       wr;
  logic [7:0] rdata;

  modport engine (output addr, output wdata, output wr, input rdata);
  modport bank   (input addr, input wdata, input wr, output rdata);
endinterface

// file: refr_serial_engine.sv
// serial management bus slave: pointer, byte writes and byte reads
`timescale 1ns/100ps
module refr_serial_engine (
  input  wire logic clk,
  input  wire logic nrst,
  input  wire logic scl_in,
  input  wire logic sda_in,
  output logic      sda_out,
  output logic      sda_oe,
  refr_bus_if.engine bus
);
  import refr_pkg::*;

  logic [2:0]  scl_s_q, scl_s_d, sda_s_q, sda_s_d;
  logic        scl_q, scl_d, sda_q, sda_d;
  refr_state_t st_q, st_d;
  refr_phase_t ph_q, ph_d;
  logic [3:0]  cnt_q, cnt_d;
  logic [7:0]  sr_q, sr_d, ptr_q, ptr_d, wdata_q, wdata_d;
  logic        rw_q, rw_d, drv_q, drv_d, wr_q, wr_d;
  logic        scl_new, sda_new, rise, fall, start, stop;

  always_comb begin
    scl_s_d = {scl_s_q[1:0], scl_in};
    sda_s_d = {sda_s_q[1:0], sda_in};
    scl_new = refr_agree(scl_q, scl_s_q[1], scl_s_q[2]);
    sda_new = refr_agree(sda_q, sda_s_q[1], sda_s_q[2]);
    scl_d   = scl_new;
    sda_d   = sda_new;
    rise    = scl_new & ~scl_q;
    fall    = ~scl_new & scl_q;
    start   = scl_q & scl_new & sda_q & ~sda_new;
    stop    = scl_q & scl_new & ~sda_q & sda_new;
    st_d    = st_q;
    ph_d    = ph_q;
    cnt_d   = cnt_q;
    sr_d    = sr_q;
    ptr_d   = ptr_q;
    rw_d    = rw_q;
    drv_d   = drv_q;
    wdata_d = wdata_q;
    wr_d    = 1'b0;
    if (start) begin
      st_d  = REFR_RX;
      ph_d  = REFR_PH_ADDR;
      cnt_d = 4'h0;
      drv_d = 1'b0;
    end else if (stop) begin
      st_d  = REFR_IDLE;
      drv_d = 1'b0;
    end else if (rise) begin
      unique case (st_q)
        REFR_RX: begin
          sr_d  = {sr_q[6:0], sda_new};
          cnt_d = cnt_q + 4'h1;
        end
        REFR_TX: cnt_d = cnt_q + 4'h1;
        REFR_TX_ACK: if (sda_new) st_d = REFR_IDLE;
        default: ;
      endcase
    end else if (fall) begin
      unique case (st_q)
        REFR_RX: if (cnt_q == BITS_BYTE) begin
          st_d  = REFR_ACK;
          drv_d = 1'b1;
          unique case (ph_q)
            REFR_PH_ADDR: begin
              rw_d = sr_q[0];
              if (sr_q[7:1] != DEV_ADDR) begin
                st_d  = REFR_IDLE;
                drv_d = 1'b0;
              end
            end
            REFR_PH_PTR: ptr_d = sr_q;
            REFR_PH_DATA: begin
              wdata_d = sr_q;
              wr_d    = 1'b1;
            end
          endcase
        end
        REFR_ACK: begin
          cnt_d = 4'h0;
          if (rw_q) begin
            st_d  = REFR_TX;
            sr_d  = bus.rdata;
            drv_d = ~bus.rdata[7];
          end else begin
            st_d  = REFR_RX;
            drv_d = 1'b0;
            // pointer advances only after the written byte is taken
            if (ph_q == REFR_PH_DATA) ptr_d = ptr_q + 8'h01;
            ph_d = (ph_q == REFR_PH_ADDR) ? REFR_PH_PTR : REFR_PH_DATA;
          end
        end
        REFR_TX: if (cnt_q == BITS_BYTE) begin
          st_d  = REFR_TX_ACK;
          drv_d = 1'b0;
          ptr_d = ptr_q + 8'h01;
        end else begin
          sr_d  = {sr_q[6:0], 1'b0};
          drv_d = ~sr_q[6];
        end
        REFR_TX_ACK: begin
          st_d  = REFR_TX;
          cnt_d = 4'h0;
          sr_d  = bus.rdata;
          drv_d = ~bus.rdata[7];
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      scl_s_q <= 3'h7;
      sda_s_q <= 3'h7;
      scl_q   <= 1'b1;
      sda_q   <= 1'b1;
      st_q    <= REFR_IDLE;
      ph_q    <= REFR_PH_ADDR;
      cnt_q   <= 4'h0;
      sr_q    <= 8'h00;
      ptr_q   <= 8'h00;
      rw_q    <= 1'b0;
      drv_q   <= 1'b0;
      wdata_q <= 8'h00;
      wr_q    <= 1'b0;
    end else begin
      scl_s_q <= scl_s_d;
      sda_s_q <= sda_s_d;
      scl_q   <= scl_d;
      sda_q   <= sda_d;
      st_q    <= st_d;
      ph_q    <= ph_d;
      cnt_q   <= cnt_d;
      sr_q    <= sr_d;
      ptr_q   <= ptr_d;
      rw_q    <= rw_d;
      drv_q   <= drv_d;
      wdata_q <= wdata_d;
      wr_q    <= wr_d;
    end
  end

  assign sda_out   = 1'b0;
  assign sda_oe    = drv_q;
  assign bus.addr  = ptr_q;
  assign bus.wdata = wdata_q;
  assign bus.wr    = wr_q;
endmodule

// file: refr_regs.sv
// rail enable, output enable, unlock key and suspend wake flag registers
`timescale 1ns/100ps

// Notes on behaviour
// RULE1: a wake flag is set only after suspend wake with that rail on.
// RULE2: wake flag register is read-only, resets to zero, fixed bit order.
// RULE3: reading the unlock key register always returns zero.
// RULE4: unlock key write gates changes of both protected enable registers.
// RULE5: converter enables in bits 5..0, reset 0, bits 7..6 read zero.
// RULE6: backup converters 5 and 6 clear only while seal status is 0; a sequencer load can still clear converter 5 at 1.
// RULE7: sequencer rewrites converters 1..5, switch 1 and linear regulator.
// RULE8: switch enables in bits 3..1, regulator bit 0, bit 7 reads zero.
// RULE9: bit 6 drives pin 3 low or releases it, unless warm reset.
// RULE10: bits 5,4 drive pins 2,1; ignored while pin 1 is input.
// RULE11: seal status 0 means fresh, 1 means broken.
// RULE12: warm reset select turns pin 3 into warm reset input.
// RULE13: input select makes pin 1 an input steering pin 2.
// RULE14: protected writes without a valid prior key write are dropped.
// RULE15: reserved enable bits ignore writes and read back as zero.
module refr_regs (
  input  wire logic       clk,
  input  wire logic       nrst,
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe,
  input  wire logic       factory_seal_status,
  input  wire logic       warm_reset_select,
  input  wire logic       pin1_input_select_alt,
  input  wire logic       seq_load,
  input  wire logic [4:0] seq_conv_on,
  input  wire logic       seq_switch1_on,
  input  wire logic       seq_linreg_on,
  input  wire logic       suspend_entry,
  input  wire logic       wake_from_suspend,
  input  wire logic       start_from_off,
  output logic [5:0]      conv_on,
  output logic [2:0]      switch_on,
  output logic            linreg_on,
  input  wire logic       pin1_in,
  output logic            pin1_out,
  output logic            pin1_oe,
  output logic            pin2_out,
  output logic            pin2_oe,
  input  wire logic       pin3_in,
  output logic            pin3_out,
  output logic            pin3_oe,
  output logic            warm_reset_req
);
  import refr_pkg::*;

  refr_bus_if bus ();

  refr_serial_engine u_engine (
    .clk     (clk),
    .nrst    (nrst),
    .scl_in  (scl_in),
    .sda_in  (sda_in),
    .sda_out (sda_out),
    .sda_oe  (sda_oe),
    .bus     (bus)
  );

  logic [7:0] conv_en_q, conv_en_d;
  logic [7:0] sw_en_q, sw_en_d;
  logic [7:0] flags_q, flags_d;
  logic [7:0] snap_q, snap_d;
  logic       armed_q, armed_d;
  logic [7:0] armed_addr_q, armed_addr_d;
  logic [2:0] p1_s_q, p1_s_d, p3_s_q, p3_s_d;
  logic       p1_lvl_q, p1_lvl_d, p3_lvl_q, p3_lvl_d;
  logic       p1_oe_q, p1_oe_d, p2_oe_q, p2_oe_d, p3_oe_q, p3_oe_d;
  logic       wrst_q, wrst_d;
  logic       key_ok;
  logic [7:0] rdata;

  // register bank state and host writes
  always_comb begin
    conv_en_d    = conv_en_q;
    sw_en_d      = sw_en_q;
    armed_d      = armed_q;
    armed_addr_d = armed_addr_q;
    key_ok       = armed_q && (armed_addr_q == bus.addr);
    if (bus.wr) begin
      if (bus.addr == ADDR_UNLOCK) begin
        // key value names the one register it opens
        armed_d      = 1'b1; // RULE4
        armed_addr_d = bus.wdata ^ UNLOCK_XOR;
      end else begin
        // any other write consumes the unlock, used or not
        armed_d = 1'b0; // RULE14
        if (key_ok && bus.addr == ADDR_CONV_EN) begin
          conv_en_d = bus.wdata & MASK_CONV_EN; // RULE5 RULE15
          if (factory_seal_status) begin
            // broken seal: host writes may set backup converters, never clear them
            conv_en_d = conv_en_d | (conv_en_q & MASK_BACKUP); // RULE6 RULE11
          end
        end
        if (key_ok && bus.addr == ADDR_SWITCH_EN) begin
          sw_en_d = bus.wdata & MASK_SWITCH_EN; // RULE8 RULE15
        end
      end
    end
    // sequencer has the last word over a host write in the same cycle
    if (seq_load) begin
      conv_en_d = (conv_en_d & ~MASK_SEQ_CONV)
                | {3'h0, seq_conv_on}; // RULE7
      sw_en_d[SWITCH1_BIT] = seq_switch1_on; // RULE7
      sw_en_d[LINREG_BIT]  = seq_linreg_on; // RULE7
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      conv_en_q    <= RST_CONV_EN;
      sw_en_q      <= RST_SWITCH_EN;
      armed_q      <= 1'b0;
      armed_addr_q <= 8'h00;
    end else begin
      conv_en_q    <= conv_en_d;
      sw_en_q      <= sw_en_d;
      armed_q      <= armed_d;
      armed_addr_q <= armed_addr_d;
    end
  end

  // wake flags: snapshot at suspend entry, published on wake
  always_comb begin
    snap_d  = snap_q;
    flags_d = flags_q;
    if (suspend_entry) begin
      snap_d = {sw_en_q[OUT3_BIT], sw_en_q[OUT2_BIT], sw_en_q[OUT1_BIT],
                sw_en_q[LINREG_BIT], conv_en_q[3:0]}; // RULE2
    end
    if (wake_from_suspend) begin
      flags_d = snap_q; // RULE1
    end else if (start_from_off) begin
      flags_d = RST_FLAGS; // RULE1
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      snap_q  <= RST_FLAGS;
      flags_q <= RST_FLAGS; // RULE2
    end else begin
      snap_q  <= snap_d;
      flags_q <= flags_d;
    end
  end

  // read mux; flags register has no write path at all
  always_comb begin
    unique case (bus.addr)
      ADDR_FLAGS:     rdata = flags_q; // RULE2
      ADDR_UNLOCK:    rdata = READ_UNLOCK; // RULE3
      ADDR_CONV_EN:   rdata = conv_en_q & MASK_CONV_EN; // RULE15
      ADDR_SWITCH_EN: rdata = sw_en_q & MASK_SWITCH_EN; // RULE15
      default:        rdata = 8'h00;
    endcase
  end
  assign bus.rdata = rdata;

  // pin sampling and open-drain drive
  always_comb begin
    p1_s_d   = {p1_s_q[1:0], pin1_in};
    p3_s_d   = {p3_s_q[1:0], pin3_in};
    p1_lvl_d = refr_agree(p1_lvl_q, p1_s_q[1], p1_s_q[2]);
    p3_lvl_d = refr_agree(p3_lvl_q, p3_s_q[1], p3_s_q[2]);
    if (pin1_input_select_alt) begin
      // pin 1 is released and its level is copied to pin 2
      p1_oe_d = 1'b0; // RULE13
      p2_oe_d = ~p1_lvl_q; // RULE10 RULE13
    end else begin
      p1_oe_d = ~sw_en_q[OUT1_BIT]; // RULE10
      p2_oe_d = ~sw_en_q[OUT2_BIT]; // RULE10
    end
    if (warm_reset_select) begin
      p3_oe_d = 1'b0; // RULE9 RULE12
      wrst_d  = ~p3_lvl_q; // RULE12
    end else begin
      p3_oe_d = ~sw_en_q[OUT3_BIT]; // RULE9
      wrst_d  = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      p1_s_q   <= 3'h7;
      p3_s_q   <= 3'h7;
      p1_lvl_q <= 1'b1;
      p3_lvl_q <= 1'b1;
      p1_oe_q  <= 1'b0;
      p2_oe_q  <= 1'b0;
      p3_oe_q  <= 1'b0;
      wrst_q   <= 1'b0;
    end else begin
      p1_s_q   <= p1_s_d;
      p3_s_q   <= p3_s_d;
      p1_lvl_q <= p1_lvl_d;
      p3_lvl_q <= p3_lvl_d;
      p1_oe_q  <= p1_oe_d;
      p2_oe_q  <= p2_oe_d;
      p3_oe_q  <= p3_oe_d;
      wrst_q   <= wrst_d;
    end
  end

  assign conv_on        = conv_en_q[5:0];
  assign switch_on      = sw_en_q[SWITCH3_BIT:SWITCH1_BIT];
  assign linreg_on      = sw_en_q[LINREG_BIT];
  // open-drain pins only ever pull low
  assign pin1_out       = 1'b0;
  assign pin2_out       = 1'b0;
  assign pin3_out       = 1'b0;
  assign pin1_oe        = p1_oe_q;
  assign pin2_oe        = p2_oe_q;
  assign pin3_oe        = p3_oe_q;
  assign warm_reset_req = wrst_q;
endmodule

// file: refr_host_model.sv
// host model: master on the serial management pins
`timescale 1ns/100ps
module refr_host_model (
  input  wire logic clk,
  input  wire logic sda,
  output logic      scl,
  output logic      sda_low
);
  import refr_pkg::*;
  // third of a bit, well above the 3-flop filter delay
  localparam int Q = 8;
  int nacks;
  initial begin
    scl = 1'h1;
    sda_low = 1'h0;
    nacks = 0;
  end
  task automatic tk();
    repeat (Q) @(negedge clk);
  endtask
  task automatic go();
    sda_low = 1'h1;
    tk();
    scl = 1'h0;
  endtask
  task automatic halt();
    tk();
    sda_low = 1'h1;
    tk();
    scl = 1'h1;
    tk();
    sda_low = 1'h0;
    tk();
  endtask
  // data moves mid-low, sampled at the end of the high phase
  task automatic bio(input logic b, output logic g);
    tk();
    sda_low = !b;
    tk();
    scl = 1'h1;
    tk();
    g = sda;
    scl = 1'h0;
  endtask
  task automatic put(input logic [7:0] v);
    logic g;
    for (int i = 7; i >= 0; i--) bio(v[i], g);
    bio(1'h1, g);
    if (g) nacks++;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    go();
    put({DEV_ADDR, 1'h0});
    put(a);
    put(d);
    halt();
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    logic g;
    go();
    put({DEV_ADDR, 1'h0});
    put(a);
    tk();
    scl = 1'h1;
    tk();
    sda_low = 1'h1;
    tk();
    scl = 1'h0;
    put({DEV_ADDR, 1'h1});
    for (int i = 7; i >= 0; i--) bio(1'h1, v[i]);
    bio(1'h1, g);
    halt();
  endtask
endmodule

// file: refr_regs_asserts.sv
// assertions on the enable and pin ports of the register bank
`timescale 1ns/100ps
module refr_regs_asserts (
  input wire logic       clk,
  input wire logic       nrst,
  input wire logic       factory_seal_status,
  input wire logic       warm_reset_select,
  input wire logic       pin1_input_select_alt,
  input wire logic       seq_load,
  input wire logic [4:0] seq_conv_on,
  input wire logic       seq_switch1_on,
  input wire logic       seq_linreg_on,
  input wire logic [5:0] conv_on,
  input wire logic [2:0] switch_on,
  input wire logic       linreg_on,
  input wire logic       pin1_in,
  input wire logic       pin1_oe,
  input wire logic       pin2_oe,
  input wire logic       pin3_in,
  input wire logic       pin3_oe,
  input wire logic       warm_reset_req
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);
  property p_p3;
    warm_reset_select && $past(warm_reset_select) |-> !pin3_oe;
  endproperty
  a_p3: assert property (p_p3)
    else $error("pin3 driven in warm mode");
  // seven samples cover filter plus register delay
  property p_wr1;
    (warm_reset_select && !pin3_in) [*7] |-> warm_reset_req;
  endproperty
  a_wr1: assert property (p_wr1)
    else $error("warm reset not raised");
  property p_wr0;
    (warm_reset_select && pin3_in) [*7] |-> !warm_reset_req;
  endproperty
  a_wr0: assert property (p_wr0)
    else $error("warm reset raised");
  property p_p1;
    pin1_input_select_alt && $past(pin1_input_select_alt) |-> !pin1_oe;
  endproperty
  a_p1: assert property (p_p1)
    else $error("pin1 driven as input");
  property p_p2l;
    (pin1_input_select_alt && !pin1_in) [*7] |-> pin2_oe;
  endproperty
  a_p2l: assert property (p_p2l)
    else $error("pin2 not following pin1");
  property p_p2h;
    (pin1_input_select_alt && pin1_in) [*7] |-> !pin2_oe;
  endproperty
  a_p2h: assert property (p_p2h)
    else $error("pin2 not following pin1");
  property p_seq;
    seq_load |=> conv_on[4:0] == $past(seq_conv_on) &&
      switch_on[0] == $past(seq_switch1_on) &&
      linreg_on == $past(seq_linreg_on);
  endproperty
  a_seq: assert property (p_seq)
    else $error("sequencer load lost");
  property p_c6;
    factory_seal_status && conv_on[5] |=> conv_on[5];
  endproperty
  a_c6: assert property (p_c6)
    else $error("backup converter cleared");
  // the sequencer may still clear converter 5, so its load is excluded
  property p_c5;
    factory_seal_status && conv_on[4] && !seq_load |=> conv_on[4];
  endproperty
  a_c5: assert property (p_c5)
    else $error("backup converter 5 cleared");
  c_seq: cover property (seq_load ##1 conv_on[0]);
  c_req: cover property (warm_reset_req);
  c_p2: cover property (pin1_input_select_alt && pin2_oe);
endmodule
bind refr_regs refr_regs_asserts u_chk (
  .clk(clk), .nrst(nrst), .factory_seal_status(factory_seal_status),
  .warm_reset_select(warm_reset_select), .seq_load(seq_load),
  .pin1_input_select_alt(pin1_input_select_alt),
  .seq_conv_on(seq_conv_on), .seq_switch1_on(seq_switch1_on),
  .seq_linreg_on(seq_linreg_on), .conv_on(conv_on),
  .switch_on(switch_on), .linreg_on(linreg_on), .pin1_in(pin1_in),
  .pin1_oe(pin1_oe), .pin2_oe(pin2_oe), .pin3_in(pin3_in),
  .pin3_oe(pin3_oe), .warm_reset_req(warm_reset_req)
);

// file: rail_enable_flag_registers_test.sv
// testbench for the rail enable and flag registers
`timescale 1ns/100ps
module rail_enable_flag_registers_test;
  import refr_pkg::*;
  logic       clk = 1'h0;
  logic       nrst = 1'h0;
  logic       seal, warm, sel, sq, ent, wake, off, p1_low, p3_low;
  logic       sq_sw, sq_lin, sda_oe, sda_out, scl, host_low, lin;
  logic       pin1_oe, pin2_oe, pin3_oe, warm_req;
  logic       pin1_out, pin2_out, pin3_out;
  logic [4:0] sq_conv;
  logic [5:0] conv;
  logic [2:0] sw;
  logic [7:0] v;
  logic [7:0] ra [5] = '{ADDR_FLAGS, ADDR_UNLOCK, ADDR_CONV_EN,
                         ADDR_SWITCH_EN, 8'h20};
  int         fail_count = 0;
  int         checks_done = 0;
  // open-drain lines with pull-ups
  wire        sda = !(host_low || (sda_oe && !sda_out));
  wire        pin1 = !((pin1_oe && !pin1_out) || p1_low);
  wire        pin3 = !((pin3_oe && !pin3_out) || p3_low);
  wire [7:0]  oes = {4'h0, warm_req, pin3_oe, pin2_oe, pin1_oe};
  wire [7:0]  en12 = {4'h0, sw, lin};
  always #5 clk = !clk;
  refr_regs u_dut (
    .clk(clk), .nrst(nrst), .scl_in(scl), .sda_in(sda),
    .sda_out(sda_out), .sda_oe(sda_oe), .factory_seal_status(seal),
    .warm_reset_select(warm), .pin1_input_select_alt(sel),
    .seq_load(sq), .seq_conv_on(sq_conv), .seq_switch1_on(sq_sw),
    .seq_linreg_on(sq_lin), .suspend_entry(ent), .wake_from_suspend(wake),
    .start_from_off(off), .conv_on(conv), .switch_on(sw),
    .linreg_on(lin), .pin1_in(pin1), .pin1_out(pin1_out),
    .pin1_oe(pin1_oe), .pin2_out(pin2_out), .pin2_oe(pin2_oe),
    .pin3_in(pin3), .pin3_out(pin3_out),
    .pin3_oe(pin3_oe), .warm_reset_req(warm_req)
  );
  refr_host_model u_host (
    .clk(clk), .sda(sda), .scl(scl), .sda_low(host_low)
  );
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] want);
    checks_done++;
    if (got !== want) begin
      fail_count++;
      $display("BAD t=%0t got=%h want=%h", $time, got, want);
    end
  endtask
  task automatic rc(input logic [7:0] a, input logic [7:0] want);
    u_host.rd(a, v);
    chk(v, want);
  endtask
  task automatic kw(input logic [7:0] a, input logic [7:0] d);
    u_host.wr(ADDR_UNLOCK, a ^ UNLOCK_XOR);
    u_host.wr(a, d);
  endtask
  task automatic pulse(ref logic s);
    @(negedge clk) s = 1'h1;
    @(negedge clk) s = 1'h0;
  endtask
  task automatic wrap_up();
    $display("checks %0d fails %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    {seal, warm, sel, sq, ent, wake, off, p1_low, p3_low} = '0;
    {sq_sw, sq_lin} = 2'h0;
    sq_conv = 5'h00;
    cyc(4);
    nrst = 1'h1;
    cyc(4);
    foreach (ra[i]) rc(ra[i], 8'h00);
    u_host.go();
    u_host.put({DEV_ADDR + 7'h1, 1'h0});
    u_host.halt();
    u_host.wr(ADDR_CONV_EN, 8'h3f);
    rc(ADDR_CONV_EN, 8'h00);
    kw(ADDR_CONV_EN, 8'hff);
    rc(ADDR_CONV_EN, 8'h3f);
    chk({2'h0, conv}, 8'h3f);
    kw(ADDR_SWITCH_EN, 8'hff);
    rc(ADDR_SWITCH_EN, 8'h7f);
    chk(en12, 8'h0f);
    chk(oes, 8'h00);
    // key armed for another offset must not open this one
    u_host.wr(ADDR_UNLOCK, ADDR_CONV_EN ^ UNLOCK_XOR);
    u_host.wr(ADDR_SWITCH_EN, 8'h00);
    rc(ADDR_SWITCH_EN, 8'h7f);
    kw(ADDR_SWITCH_EN, 8'h0f);
    chk(oes, 8'h07);
    chk({5'h00, pin3_out, pin2_out, pin1_out}, 8'h00);
    warm = 1'h1;
    cyc(10);
    chk(oes, 8'h03);
    p3_low = 1'h1;
    cyc(10);
    chk(oes, 8'h0b);
    p3_low = 1'h0;
    warm = 1'h0;
    sel = 1'h1;
    cyc(10);
    chk(oes, 8'h04);
    p1_low = 1'h1;
    cyc(10);
    chk(oes, 8'h06);
    seal = 1'h1;
    kw(ADDR_CONV_EN, 8'h00);
    rc(ADDR_CONV_EN, 8'h30);
    seal = 1'h0;
    kw(ADDR_CONV_EN, 8'h00);
    rc(ADDR_CONV_EN, 8'h00);
    sq_conv = 5'h15;
    sq_lin = 1'h1;
    pulse(sq);
    rc(ADDR_CONV_EN, 8'h15);
    rc(ADDR_SWITCH_EN, 8'h0d);
    kw(ADDR_SWITCH_EN, 8'h31);
    pulse(ent);
    // rails change after the snapshot, flags must not follow
    sq_conv = 5'h00;
    pulse(sq);
    pulse(wake);
    rc(ADDR_FLAGS, 8'h75);
    u_host.wr(ADDR_FLAGS, 8'h00);
    rc(ADDR_FLAGS, 8'h75);
    pulse(off);
    rc(ADDR_FLAGS, 8'h00);
    // reset mid-run: enables and pin drives fall back to zero
    nrst = 1'h0;
    cyc(2);
    chk({2'h0, conv}, RST_CONV_EN);
    chk(en12, RST_SWITCH_EN);
    chk(oes, 8'h00);
    nrst = 1'h1;
    cyc(4);
    rc(ADDR_SWITCH_EN, RST_SWITCH_EN);
    chk(8'(u_host.nacks), 8'h01);
    wrap_up();
  end
  initial begin
    cyc(60000);
    fail_count++;
    wrap_up();
  end
endmodule
